// file: pkg/pafp_pkg.sv
// Package for the port alternate-function pin block: register map, field layout,
// reset values and the segment-line select encoding.
// Assumes a 32-bit AHB-Lite register bus, port registers at byte addresses two apart, the rest four apart.
package pafp_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PA_WIDTH     = 16;
  localparam int P4_WIDTH     = 8;
  localparam int SAL_WIDTH    = 2;
  // ****************************************************************
  // Register byte addresses (low 16 bits of haddr)
  // ****************************************************************
  localparam logic [15:0] ADDR_PORT_A_DATA = 16'hffc4;
  localparam logic [15:0] ADDR_PORT_A_DIR  = 16'hffc6;
  localparam logic [15:0] ADDR_PORT4_DATA  = 16'hffc8;
  localparam logic [15:0] ADDR_PORT4_DIR   = 16'hffca;
  localparam logic [15:0] ADDR_BUS_CFG     = 16'hffd0;
  localparam logic [15:0] ADDR_RESET_CFG   = 16'hffd4;
  localparam logic [15:0] ADDR_PIN_STATE   = 16'hffd8;
  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [15:0] PORT_A_RESET    = 16'h0000;
  localparam logic [7:0]  PORT4_RESET     = 8'h00;
  localparam logic [15:0] PORT_A_MASK     = 16'hbfff;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;
  // ****************************************************************
  // Pin positions on the 15-bit port
  // ****************************************************************
  localparam int PIN_TIMER6_TOGGLE_OUT   = 1;
  localparam int PIN_TIMER_CAPTURE_IN   = 2;
  localparam int PIN_TIMER3_TOGGLE_OUT   = 3;
  localparam int PIN_T3UD    = 4;
  localparam int PIN_TIMER4_COUNT_IN    = 5;
  localparam int PIN_TIMER3_COUNT_IN    = 6;
  localparam int PIN_TIMER2_COUNT_IN    = 7;
  localparam int PIN_SS_RX   = 8;
  localparam int PIN_SS_TX   = 9;
  localparam int PIN_ATX     = 10;
  localparam int PIN_ARX     = 11;
  localparam int PIN_BHE     = 12;
  localparam int PIN_SCLK    = 13;
  localparam int PIN_NONE    = 14;
  localparam int PIN_SYSTEM_CLOCK_OUT  = 15;
  // ****************************************************************
  // Bus configuration register fields
  // ****************************************************************
  localparam int CFG_BYTE_HIGH_DISABLE  = 0;
  localparam int CFG_WRITE_SIGNAL_CONFIG   = 1;
  localparam int CFG_CLKEN   = 2;
  localparam int CFG_SSPEN   = 3;
  localparam logic [3:0] BUS_CFG_RESET = 4'h0;
  // ****************************************************************
  // Segment line select encoding
  // ****************************************************************
  typedef enum logic [1:0] {
    PAFP_SAL_1M   = 2'b00,
    PAFP_SAL_64K  = 2'b01,
    PAFP_SAL_16M  = 2'b10,
    PAFP_SAL_256K = 2'b11
  } pafp_sal_type;
  localparam logic [7:0] SEG_MASK_64K  = 8'h00;
  localparam logic [7:0] SEG_MASK_256K = 8'h03;
  localparam logic [7:0] SEG_MASK_1M   = 8'h0f;
  localparam logic [7:0] SEG_MASK_16M  = 8'hff;
  localparam int SAL_STRAP_LSB = 11;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage : pafp_pkg

// file: rtl/pafp_sync.sv
// Three-stage synchroniser bank with change qualification.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module pafp_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  import pafp_pkg::*;
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      q_out  <= '0;
    end else begin
      stage1 <= d_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          q_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pafp_sync

// file: rtl/pafp_port.sv
// Port alternate-function pin block: 15-bit shared port and 8-bit segment port.
// Assumes an AHB-Lite master on SYS_CLK_IN, pins resolved outside from out/oe.
// Notes on behaviour
// - Alternate output pin value, except the line 12 strobe, is peripheral output ANDed with port latch bit.
// - Unused peripheral alternate outputs rest high.
// - Peripherals read alternate inputs from the synchronised port input latch.
// - Alternate inputs on lines 2, 4, 5, 6, 7 feed capture and timers.
// - Alternate outputs on lines 1, 3, 10 and 15.
// - Reduced variant drops sync serial functions on lines 8, 9, 13: their alternate outputs rest high and their inputs read zero.
// - Clock output enable forces line 15 driver on regardless of direction.
// - After reset line 12 takes byte-high, as the bus config register resets to zero.
// - Byte disable set and write config clear returns line 12 to GPIO.
// - Byte-high or write-high function forces line 12 driver on.
// - During bus hold line 12 uses only its direction and latch bits.
// - 8-bit port data and direction registers in bits 7..0, reset zero.
// - 8-bit port direction zero means input, one means driven output.
// - Selected 8-bit pins output segment address; others stay GPIO.
// - Segment address function is active right after reset.
// - Segment line count latched from lower data port at reset, readable.
// - Reduced variant with sync serial port limits segment lines to four.
// - 15-bit port line direction zero is input, one is output.
// - Data bit 14 exists but drives no pin.
`timescale 1ns/1ps
module pafp_port #(
  parameter bit HAS_SYNC_SERIAL = 1'b1
) (
  input  wire logic                              SYS_CLK_IN,
  input  wire logic                              RESET_IN,
  // AHB-Lite slave
  input  wire logic                              HSEL_IN,
  input  wire logic [31:0]                       HADDR_IN,
  input  wire logic [1:0]                        HTRANS_IN,
  input  wire logic                              HWRITE_IN,
  input  wire logic [2:0]                        HSIZE_IN,
  input  wire logic [31:0]                       HWDATA_IN,
  input  wire logic                              HREADY_IN,
  output logic      [31:0]                       HRDATA_OUT,
  output logic                                   HREADYOUT_OUT,
  output logic                                   HRESP_OUT,
  // 15-bit port pins
  input  wire logic [pafp_pkg::PA_WIDTH-1:0]     PORT_A_PIN_IN,
  output logic      [pafp_pkg::PA_WIDTH-1:0]     PORT_A_PIN_OUT,
  output logic      [pafp_pkg::PA_WIDTH-1:0]     PORT_A_PIN_OE_OUT,
  // 8-bit port pins
  input  wire logic [pafp_pkg::P4_WIDTH-1:0]     PORT4_PIN_IN,
  output logic      [pafp_pkg::P4_WIDTH-1:0]     PORT4_PIN_OUT,
  output logic      [pafp_pkg::P4_WIDTH-1:0]     PORT4_PIN_OE_OUT,
  // Startup straps and bus state
  input  wire logic [15:0]                       LOWER_DATA_PORT_IN,
  input  wire logic                              BUS_HOLD_IN,
  input  wire logic                              SEGMENT_CYCLE_IN,
  input  wire logic [pafp_pkg::P4_WIDTH-1:0]     SEGMENT_ADDR_IN,
  // Peripheral alternate outputs
  input  wire logic                              TIMER6_TOGGLE_IN,
  input  wire logic                              TIMER3_TOGGLE_IN,
  input  wire logic                              ASYNC_SERIAL_TX_IN,
  input  wire logic                              SYSTEM_CLOCK_IN,
  input  wire logic                              BYTE_HIGH_ENABLE_N_IN,
  input  wire logic                              WRITE_HIGH_N_IN,
  input  wire logic                              SYNC_TX_MASTER_IN,
  input  wire logic                              SYNC_RX_MASTER_IN,
  input  wire logic                              SYNC_CLK_IN,
  // Peripheral alternate inputs
  output logic                                   TIMER_CAPTURE_IN_OUT,
  output logic                                   TIMER3_UPDOWN_IN_OUT,
  output logic                                   TIMER4_COUNT_IN_OUT,
  output logic                                   TIMER3_COUNT_IN_OUT,
  output logic                                   TIMER2_COUNT_IN_OUT,
  output logic                                   ASYNC_SERIAL_RX_OUT,
  output logic                                   SYNC_RX_MASTER_OUT,
  output logic                                   SYNC_TX_MASTER_OUT,
  output logic                                   SYNC_CLK_OUT
);
  import pafp_pkg::*;

  // The register layout only serves these widths
  if (PA_WIDTH != 16 || P4_WIDTH != 8) begin : g_bad_width
    $error("pafp_port: unsupported port width");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [PA_WIDTH-1:0] port_a_data;
  logic [PA_WIDTH-1:0] port_a_direction;
  logic [P4_WIDTH-1:0] port4_data;
  logic [P4_WIDTH-1:0] port4_direction;
  logic [3:0]          bus_cfg;
  logic [SAL_WIDTH-1:0] segment_line_select;
  logic                strap_pending;
  logic                dphase_valid;
  logic                dphase_write;
  logic [15:0]         dphase_addr;
  logic [PA_WIDTH-1:0] port_a_latch;
  logic [P4_WIDTH-1:0] port4_latch;

  // ****************************************************************
  // Input latches
  // ****************************************************************
  pafp_sync #(.WIDTH(PA_WIDTH)) u_sync_a (
    .clk_in   (SYS_CLK_IN),
    .reset_in (RESET_IN),
    .d_in     (PORT_A_PIN_IN),
    .q_out    (port_a_latch)
  );

  pafp_sync #(.WIDTH(P4_WIDTH)) u_sync_4 (
    .clk_in   (SYS_CLK_IN),
    .reset_in (RESET_IN),
    .d_in     (PORT4_PIN_IN),
    .q_out    (port4_latch)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        addr_taken    = HSEL_IN && HREADY_IN &&
                              (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ);
  wire        wr_en         = dphase_valid && dphase_write;
  wire        sel_a_data    = dphase_addr == ADDR_PORT_A_DATA;
  wire        sel_a_dir     = dphase_addr == ADDR_PORT_A_DIR;
  wire        sel_4_data    = dphase_addr == ADDR_PORT4_DATA;
  wire        sel_4_dir     = dphase_addr == ADDR_PORT4_DIR;
  wire        sel_cfg       = dphase_addr == ADDR_BUS_CFG;
  wire        sel_rcfg      = dphase_addr == ADDR_RESET_CFG;
  wire        sel_pins      = dphase_addr == ADDR_PIN_STATE;
  wire [15:0] wdata16       = HWDATA_IN[15:0];

  // ****************************************************************
  // Control decode
  // ****************************************************************
  wire byte_high_disable   = bus_cfg[CFG_BYTE_HIGH_DISABLE];
  wire write_signal_config = bus_cfg[CFG_WRITE_SIGNAL_CONFIG];
  wire system_clock_out_enable       = bus_cfg[CFG_CLKEN];
  wire sync_port_lite_on   = bus_cfg[CFG_SSPEN];
  // Line 12 carries a bus strobe unless disabled or bus held
  wire bhe_mode            = !write_signal_config && !byte_high_disable;
  wire wrh_mode            = write_signal_config;
  wire line12_alt          = (bhe_mode || wrh_mode) && !BUS_HOLD_IN;
  wire line12_value        = wrh_mode ? WRITE_HIGH_N_IN : BYTE_HIGH_ENABLE_N_IN;

  // Segment lines, limited on reduced variant with port-lite active
  wire [7:0] seg_mask_raw  = (segment_line_select == PAFP_SAL_256K) ? SEG_MASK_256K :
                             (segment_line_select == PAFP_SAL_1M)   ? SEG_MASK_1M   :
                             (segment_line_select == PAFP_SAL_16M)  ? SEG_MASK_16M  :
                                                                     SEG_MASK_64K;
  wire       seg_limit     = !HAS_SYNC_SERIAL && sync_port_lite_on;
  wire [7:0] seg_mask      = seg_limit ? (seg_mask_raw & SEG_MASK_1M) : seg_mask_raw;
  wire [7:0] seg_drive     = seg_mask & {P4_WIDTH{SEGMENT_CYCLE_IN}};

  // Alternate output values, high when unused
  logic [PA_WIDTH-1:0] alt_out;
  always_comb begin
    alt_out                = {PA_WIDTH{1'b1}};
    alt_out[PIN_TIMER6_TOGGLE_OUT]     = TIMER6_TOGGLE_IN;
    alt_out[PIN_TIMER3_TOGGLE_OUT]     = TIMER3_TOGGLE_IN;
    alt_out[PIN_ATX]       = ASYNC_SERIAL_TX_IN;
    alt_out[PIN_SYSTEM_CLOCK_OUT]    = system_clock_out_enable ? SYSTEM_CLOCK_IN : 1'b1;
    if (HAS_SYNC_SERIAL) begin
      alt_out[PIN_SS_RX]   = SYNC_RX_MASTER_IN;
      alt_out[PIN_SS_TX]   = SYNC_TX_MASTER_IN;
      alt_out[PIN_SCLK]    = SYNC_CLK_IN;
    end
  end

  logic [PA_WIDTH-1:0] next_pin_a;
  logic [PA_WIDTH-1:0] next_oe_a;
  always_comb begin
    next_pin_a             = alt_out & port_a_data;
    next_oe_a              = port_a_direction;
    next_oe_a[PIN_SYSTEM_CLOCK_OUT]  = port_a_direction[PIN_SYSTEM_CLOCK_OUT] || system_clock_out_enable;
    if (line12_alt) begin
      next_pin_a[PIN_BHE]  = line12_value;
      next_oe_a[PIN_BHE]   = 1'b1;
    end
    next_pin_a[PIN_NONE]   = 1'b0;
    next_oe_a[PIN_NONE]    = 1'b0;
  end

  // A segment line ignores the port latch while its cycle runs
  logic [P4_WIDTH-1:0] next_pin_4;
  for (genvar i = 0; i < P4_WIDTH; i++) begin : g_seg_pin
    assign next_pin_4[i] = seg_drive[i] ? SEGMENT_ADDR_IN[i] : port4_data[i];
  end
  wire [7:0] next_oe_4  = seg_mask | port4_direction;

  logic [31:0] read_mux;
  always_comb begin
    read_mux = READ_ZERO;
    if (sel_a_data) begin
      read_mux[15:0] = port_a_data;
    end else if (sel_a_dir) begin
      read_mux[15:0] = port_a_direction;
    end else if (sel_4_data) begin
      read_mux[7:0] = port4_data;
    end else if (sel_4_dir) begin
      read_mux[7:0] = port4_direction;
    end else if (sel_cfg) begin
      read_mux[3:0] = bus_cfg;
    end else if (sel_rcfg) begin
      read_mux[SAL_WIDTH-1:0] = segment_line_select;
    end else if (sel_pins) begin
      read_mux[15:0]  = port_a_latch;
      read_mux[23:16] = port4_latch;
    end
  end

  // ****************************************************************
  // Bus phase tracking
  // ****************************************************************
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      dphase_valid <= 1'b0;
      dphase_write <= 1'b0;
      dphase_addr  <= 16'h0000;
    end else if (HREADY_IN) begin
      dphase_valid <= addr_taken;
      dphase_write <= HWRITE_IN;
      dphase_addr  <= HADDR_IN[15:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      // A read waits one cycle so the data comes from a flip-flop
      HREADYOUT_OUT <= !(addr_taken && !HWRITE_IN);
      HRESP_OUT     <= 1'b0;
    end
  end

  // Read data stands until the next read replaces it
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      HRDATA_OUT <= READ_ZERO;
    end else if (dphase_valid && !dphase_write && !HREADYOUT_OUT) begin
      HRDATA_OUT <= read_mux;
    end
  end

  // ****************************************************************
  // Port registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      port_a_data      <= PORT_A_RESET;
      port_a_direction <= PORT_A_RESET;
      port4_data       <= PORT4_RESET;
      port4_direction  <= PORT4_RESET;
    end else if (wr_en) begin
      // Bit 14 is kept in the data register although no pin shows it
      if (sel_a_data) port_a_data <= wdata16;
      if (sel_a_dir)  port_a_direction <= wdata16 & PORT_A_MASK;
      if (sel_4_data) port4_data <= wdata16[P4_WIDTH-1:0];
      if (sel_4_dir)  port4_direction <= wdata16[P4_WIDTH-1:0];
    end
  end

  // Reset value puts the byte-high strobe on line 12 at once
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      bus_cfg <= BUS_CFG_RESET;
    end else if (wr_en && sel_cfg) begin
      bus_cfg <= wdata16[3:0];
    end
  end

  // Segment line strap caught on the first edge after reset release
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      strap_pending       <= 1'b1;
      segment_line_select <= PAFP_SAL_64K;
    end else if (strap_pending) begin
      strap_pending       <= 1'b0;
      segment_line_select <= LOWER_DATA_PORT_IN[SAL_STRAP_LSB +: SAL_WIDTH];
    end
  end

  // ****************************************************************
  // Pin outputs and alternate inputs
  // ****************************************************************
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PORT_A_PIN_OUT       <= '0;
      PORT_A_PIN_OE_OUT    <= '0;
      PORT4_PIN_OUT        <= '0;
      PORT4_PIN_OE_OUT     <= '0;
    end else begin
      PORT_A_PIN_OUT       <= next_pin_a;
      PORT_A_PIN_OE_OUT    <= next_oe_a;
      PORT4_PIN_OUT        <= next_pin_4;
      PORT4_PIN_OE_OUT     <= next_oe_4;
    end
  end

  // Peripherals see the synchronised latch, never the raw pin
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      TIMER_CAPTURE_IN_OUT <= 1'b0;
      TIMER3_UPDOWN_IN_OUT <= 1'b0;
      TIMER4_COUNT_IN_OUT  <= 1'b0;
      TIMER3_COUNT_IN_OUT  <= 1'b0;
      TIMER2_COUNT_IN_OUT  <= 1'b0;
      ASYNC_SERIAL_RX_OUT  <= 1'b0;
      SYNC_RX_MASTER_OUT   <= 1'b0;
      SYNC_TX_MASTER_OUT   <= 1'b0;
      SYNC_CLK_OUT         <= 1'b0;
    end else begin
      TIMER_CAPTURE_IN_OUT <= port_a_latch[PIN_TIMER_CAPTURE_IN];
      TIMER3_UPDOWN_IN_OUT <= port_a_latch[PIN_T3UD];
      TIMER4_COUNT_IN_OUT  <= port_a_latch[PIN_TIMER4_COUNT_IN];
      TIMER3_COUNT_IN_OUT  <= port_a_latch[PIN_TIMER3_COUNT_IN];
      TIMER2_COUNT_IN_OUT  <= port_a_latch[PIN_TIMER2_COUNT_IN];
      ASYNC_SERIAL_RX_OUT  <= port_a_latch[PIN_ARX];
      SYNC_RX_MASTER_OUT   <= HAS_SYNC_SERIAL && port_a_latch[PIN_SS_RX];
      SYNC_TX_MASTER_OUT   <= HAS_SYNC_SERIAL && port_a_latch[PIN_SS_TX];
      SYNC_CLK_OUT         <= HAS_SYNC_SERIAL && port_a_latch[PIN_SCLK];
    end
  end
endmodule : pafp_port

// file: tb/pafp_pin_model.sv
// Board side of both ports: resolves every pin from the block's drive and the board.
// Assumes board pull-ups on all lines; the bench may drive released port A lines.
`timescale 1ns/1ps
module pafp_pin_model (
  input  wire logic [15:0] a_out_in,
  input  wire logic [15:0] a_oe_in,
  input  wire logic [15:0] ext_a_in,
  input  wire logic [15:0] ext_a_en_in,
  output logic      [15:0] a_pin_out,
  input  wire logic [7:0]  p4_out_in,
  input  wire logic [7:0]  p4_oe_in,
  output logic      [7:0]  p4_pin_out
);
  // ********
  // Pin resolution, released lines go to the bench level where driven, else the pull-up level
  // ********
  assign a_pin_out  = (a_oe_in & a_out_in) | (~a_oe_in & ((ext_a_en_in & ext_a_in) | ~ext_a_en_in));
  assign p4_pin_out = (p4_oe_in & p4_out_in) | ~p4_oe_in;
endmodule : pafp_pin_model

// file: tb/pafp_port_asserts.sv
// Checker for the port alternate-function pin block.
// Sees only the top module's ports; bound to pafp_port at the foot of this file.
`timescale 1ns/1ps
module pafp_port_asserts (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic        HSEL_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic [15:0] PORT_A_PIN_IN,
  input wire logic [15:0] PORT_A_PIN_OUT,
  input wire logic [15:0] PORT_A_PIN_OE_OUT,
  input wire logic        BUS_HOLD_IN,
  input wire logic        SEGMENT_CYCLE_IN,
  input wire logic        TIMER6_TOGGLE_IN,
  input wire logic        TIMER3_TOGGLE_IN,
  input wire logic        ASYNC_SERIAL_TX_IN,
  input wire logic        TIMER_CAPTURE_IN_OUT,
  input wire logic        ASYNC_SERIAL_RX_OUT
);
  import pafp_pkg::*;
  wire rd_taken = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
  wire wr_taken = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ********
  // Assertions
  // ********
  AST_BUS_OKAY: assert property (HRESP_OUT == 1'b0) else $error("response not okay");
  AST_READ_WAIT: assert property (rd_taken |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_taken |=> HREADYOUT_OUT) else $error("write stalled");
  AST_RDATA_HOLD: assert property ($changed(HRDATA_OUT) |-> $past(rd_taken, 2))
    else $error("read data changed without a read");
  AST_T6_AND: assert property (PORT_A_PIN_OUT[PIN_TIMER6_TOGGLE_OUT] |-> $past(TIMER6_TOGGLE_IN))
    else $error("line 1 high while timer output low");
  AST_T3_AND: assert property (PORT_A_PIN_OUT[PIN_TIMER3_TOGGLE_OUT] |-> $past(TIMER3_TOGGLE_IN))
    else $error("line 3 high while timer output low");
  AST_TX_AND: assert property (PORT_A_PIN_OUT[PIN_ATX] |-> $past(ASYNC_SERIAL_TX_IN))
    else $error("line 10 high while transmit low");
  AST_NO_PIN14: assert property (!PORT_A_PIN_OE_OUT[PIN_NONE])
    else $error("line 14 driven");
  AST_CAPTURE_FOLLOW: assert property ($stable(PORT_A_PIN_IN[PIN_TIMER_CAPTURE_IN]) [*8] |->
    TIMER_CAPTURE_IN_OUT == PORT_A_PIN_IN[PIN_TIMER_CAPTURE_IN]) else $error("capture input stale");
  AST_RX_FOLLOW: assert property ($stable(PORT_A_PIN_IN[PIN_ARX]) [*8] |->
    ASYNC_SERIAL_RX_OUT == PORT_A_PIN_IN[PIN_ARX]) else $error("receive input stale");
  COV_READ: cover property (rd_taken ##2 HREADYOUT_OUT);
  COV_WRITE: cover property (wr_taken);
  COV_HOLD: cover property (BUS_HOLD_IN);
  COV_SEGMENT: cover property (SEGMENT_CYCLE_IN);
endmodule : pafp_port_asserts
bind pafp_port pafp_port_asserts u_asserts (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
  .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
  .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .PORT_A_PIN_IN(PORT_A_PIN_IN), .PORT_A_PIN_OUT(PORT_A_PIN_OUT),
  .PORT_A_PIN_OE_OUT(PORT_A_PIN_OE_OUT), .BUS_HOLD_IN(BUS_HOLD_IN),
  .SEGMENT_CYCLE_IN(SEGMENT_CYCLE_IN), .TIMER6_TOGGLE_IN(TIMER6_TOGGLE_IN),
  .TIMER3_TOGGLE_IN(TIMER3_TOGGLE_IN), .ASYNC_SERIAL_TX_IN(ASYNC_SERIAL_TX_IN),
  .TIMER_CAPTURE_IN_OUT(TIMER_CAPTURE_IN_OUT), .ASYNC_SERIAL_RX_OUT(ASYNC_SERIAL_RX_OUT));

// file: tb/pafp_port_test.sv
// Self-checking bench for the port alternate-function pin block.
// Assumes the pin model on both ports and a single AHB-Lite master here.
`timescale 1ns/1ps
module pafp_port_test;
  import pafp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, v;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [15:0] a_out, a_oe, a_pin, ext_a = '0, ext_a_en = '0;
  logic [7:0] p4_out, p4_oe, p4_pin, sega = '0;
  logic hold = 1'b0, segc = 1'b0, t6 = 1'b1, t3 = 1'b1, atx = 1'b1, bhe_n = 1'b1, wrh_n = 1'b1;
  logic cap, ud, c4, c3, c2, arx, srx, stx, sck;
  int failures = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  pafp_port uut (.SYS_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .PORT_A_PIN_IN(a_pin), .PORT_A_PIN_OUT(a_out), .PORT_A_PIN_OE_OUT(a_oe),
    .PORT4_PIN_IN(p4_pin), .PORT4_PIN_OUT(p4_out), .PORT4_PIN_OE_OUT(p4_oe),
    .LOWER_DATA_PORT_IN(16'h1800), .BUS_HOLD_IN(hold), .SEGMENT_CYCLE_IN(segc),
    .SEGMENT_ADDR_IN(sega), .TIMER6_TOGGLE_IN(t6), .TIMER3_TOGGLE_IN(t3),
    .ASYNC_SERIAL_TX_IN(atx), .SYSTEM_CLOCK_IN(1'b1), .BYTE_HIGH_ENABLE_N_IN(bhe_n),
    .WRITE_HIGH_N_IN(wrh_n), .SYNC_TX_MASTER_IN(1'b1), .SYNC_RX_MASTER_IN(1'b1),
    .SYNC_CLK_IN(1'b1), .TIMER_CAPTURE_IN_OUT(cap), .TIMER3_UPDOWN_IN_OUT(ud),
    .TIMER4_COUNT_IN_OUT(c4), .TIMER3_COUNT_IN_OUT(c3), .TIMER2_COUNT_IN_OUT(c2),
    .ASYNC_SERIAL_RX_OUT(arx), .SYNC_RX_MASTER_OUT(srx), .SYNC_TX_MASTER_OUT(stx),
    .SYNC_CLK_OUT(sck));
  pafp_pin_model board (.a_out_in(a_out), .a_oe_in(a_oe), .ext_a_in(ext_a),
    .ext_a_en_in(ext_a_en), .a_pin_out(a_pin), .p4_out_in(p4_out), .p4_oe_in(p4_oe),
    .p4_pin_out(p4_pin));
  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= {16'h0000, a}; hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0000_0000);
    chk(v, exp, what);
  endtask : rdc
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // ********
  // Tests
  // ********
  initial begin
    #100us;
    failures++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle(3);
    chk(32'(p4_oe), 32'(SEG_MASK_256K), "segment drivers after reset");
    chk(32'(a_oe[PIN_BHE]), 32'h1, "line 12 driver after reset");
    chk(32'(a_out[PIN_BHE]), 32'h1, "line 12 byte-high value");
    rdc(ADDR_PORT4_DATA, 32'h0, "port4 data reset");
    rdc(ADDR_PORT4_DIR, 32'h0, "port4 direction reset");
    rdc(ADDR_RESET_CFG, 32'h3, "segment select strap");
    rdc(16'hffe0, READ_ZERO, "unmapped read");
    $display("reset test done");
    bus(ADDR_PORT4_DATA, 1'b1, 32'h12a5);
    bus(ADDR_PORT4_DIR, 1'b1, 32'hffff);
    settle(2);
    chk(32'(p4_oe), 32'hff, "port4 drivers on");
    chk(32'(p4_out), 32'ha5, "port4 latch out");
    rdc(ADDR_PORT4_DATA, 32'ha5, "port4 data width");
    @(posedge clk);
    segc <= 1'b1;
    sega <= 8'h5a;
    settle(2);
    chk(32'(p4_out), 32'ha6, "segment lines mixed with gpio");
    bus(ADDR_PORT4_DIR, 1'b1, 32'h0);
    settle(2);
    chk(32'(p4_oe), 32'h03, "segment drivers ignore direction");
    @(posedge clk);
    segc <= 1'b0;
    $display("port4 test done");
    bus(ADDR_PORT_A_DIR, 1'b1, 32'hffff);
    rdc(ADDR_PORT_A_DIR, 32'(PORT_A_MASK), "line 14 direction");
    bus(ADDR_PORT_A_DIR, 1'b1, 32'h040a);
    bus(ADDR_PORT_A_DATA, 1'b1, 32'h040a);
    t6 <= 1'b0;
    settle(2);
    chk(32'(a_oe[11:0]), 32'h40a, "port A direction");
    chk(32'(a_out[11:0] & 12'h40a), 32'h408, "alternate outputs");
    bus(ADDR_PORT_A_DATA, 1'b1, 32'h0402);
    settle(2);
    chk(32'(a_out[11:0] & 12'h40a), 32'h400, "latch masks timer output");
    chk(32'(a_oe[PIN_NONE]), 32'h0, "line 14 undriven");
    $display("alternate output test done");
    bus(ADDR_BUS_CFG, 1'b1, 32'h5);
    settle(2);
    chk(32'(a_oe[PIN_SYSTEM_CLOCK_OUT]), 32'h1, "clock output driver");
    chk(32'(a_oe[PIN_BHE]), 32'h0, "line 12 back to gpio");
    bus(ADDR_BUS_CFG, 1'b1, 32'h7);
    wrh_n <= 1'b0;
    settle(2);
    chk(32'(a_oe[PIN_BHE]), 32'h1, "write-high driver");
    chk(32'(a_out[PIN_BHE]), 32'h0, "write-high value");
    @(posedge clk);
    hold <= 1'b1;
    settle(2);
    chk(32'(a_oe[PIN_BHE]), 32'h0, "line 12 floats in hold");
    @(posedge clk);
    hold <= 1'b0;
    $display("bus control test done");
    bus(ADDR_PORT_A_DIR, 1'b1, 32'h0);
    for (int i = 0; i < 2; i++) begin
      ext_a_en <= 16'hffff;
      ext_a <= (i == 0) ? 16'h08a4 : 16'hf75b;
      settle(8);
      chk(32'({cap, ud, c4, c3, c2, arx}), (i == 0) ? 32'h2b : 32'h14, "alternate inputs");
      chk(32'({srx, stx, sck}), (i == 0) ? 32'h0 : 32'h7, "sync serial inputs");
      @(posedge clk);
    end
    $display("alternate input test done");
    summarize();
  end
endmodule : pafp_port_test
